// file: core/eeprom_pkg.sv
// constants, states and timing of the two-wire 512-byte serial memory slave
package eeprom_pkg;
  localparam int          CLK_PERIOD_NS      = 4;
  localparam int          PROGRAM_CYCLE_TIME = 3000000;
  localparam int          PROG_CYCLES        = PROGRAM_CYCLE_TIME / CLK_PERIOD_NS;
  localparam int          PROG_CNT_W         = 20;
  localparam int          ADDR_W             = 9;
  localparam int          MEM_DEPTH          = 512;
  localparam int          PAGE_BYTES         = 16;
  localparam int          PAGE_IDX_W         = 4;
  localparam logic [3:0]  DEV_CODE           = 4'hA;
  localparam logic [2:0]  LAST_BIT           = 3'h7;
  localparam logic [4:0]  SYNC_IDLE          = 5'h18;

  typedef enum logic [2:0] {
    S_IDLE,
    S_DEVADDR,
    S_WADDR,
    S_WDATA,
    S_ACK,
    S_RDATA,
    S_RACK,
    S_PROG
  } state_e;
endpackage

// file: core/i2c_eeprom_slave_512b.sv
// two-wire serial memory slave: 512 bytes, 16-byte pages, timed programming
`timescale 1ns/1ps
module i2c_eeprom_slave_512b #(
  parameter int PROG_CYCLES = eeprom_pkg::PROG_CYCLES
) (
  input  wire logic CORE_CLK,               // core clock, 250 MHz
  input  wire logic RST_N,                  // synchronous reset, active low
  input  wire logic SCL,                    // serial clock from the master
  input  wire logic SDA_IN,                 // serial data line level
  output logic      SDA_OUT,                // serial data drive value, always low
  output logic      SDA_OE_N,               // data drive enable, low pulls line low
  input  wire logic WRITE_PROTECT,          // high blocks programming
  input  wire logic CHIP_SELECT_STRAP_HIGH, // address strap, upper
  input  wire logic CHIP_SELECT_STRAP_LOW,  // address strap, lower
  output logic      STANDBY                 // high while in standby
);
  localparam logic [eeprom_pkg::PROG_CNT_W-1:0] PROG_LAST = eeprom_pkg::PROG_CNT_W'(PROG_CYCLES - 1);

  // link domain: sample data on clock rise, flag each bit with a toggle
  logic link_rst_n_q;
  logic link_bit_q;
  logic link_tog_q;

  always_ff @(posedge CORE_CLK) begin
    link_rst_n_q <= RST_N;
  end

  always_ff @(posedge SCL or negedge link_rst_n_q) begin
    if (!link_rst_n_q) begin
      link_bit_q <= 1'h0;
      link_tog_q <= 1'h0;
    end else begin
      link_bit_q <= SDA_IN;
      link_tog_q <= ~link_tog_q;
    end
  end

  // two-flop synchronisers for pins and link signals
  logic [4:0] pin_s1_q;
  logic [4:0] pin_s2_q;
  logic [1:0] lnk_s1_q;
  logic [1:0] lnk_s2_q;
  logic       scl_p_q;
  logic       sda_p_q;
  logic       tog_p_q;

  always_ff @(posedge CORE_CLK) begin
    if (!RST_N) begin
      pin_s1_q <= eeprom_pkg::SYNC_IDLE;
      pin_s2_q <= eeprom_pkg::SYNC_IDLE;
      lnk_s1_q <= 2'h0;
      lnk_s2_q <= 2'h0;
      scl_p_q  <= 1'h1;
      sda_p_q  <= 1'h1;
      tog_p_q  <= 1'h0;
    end else begin
      pin_s1_q <= {SCL, SDA_IN, WRITE_PROTECT, CHIP_SELECT_STRAP_HIGH, CHIP_SELECT_STRAP_LOW};
      pin_s2_q <= pin_s1_q;
      lnk_s1_q <= {link_tog_q, link_bit_q};
      lnk_s2_q <= lnk_s1_q;
      scl_p_q  <= pin_s2_q[4];
      sda_p_q  <= pin_s2_q[3];
      tog_p_q  <= lnk_s2_q[1];
    end
  end

  logic scl_s;
  logic sda_s;
  logic wp_s;
  logic strap_h_s;
  logic strap_l_s;
  logic bit_s;
  logic start_ev;
  logic stop_ev;
  logic rise_ev;
  logic fall_ev;

  assign scl_s     = pin_s2_q[4];
  assign sda_s     = pin_s2_q[3];
  assign wp_s      = pin_s2_q[2];
  assign strap_h_s = pin_s2_q[1];
  assign strap_l_s = pin_s2_q[0];
  assign bit_s     = lnk_s2_q[0];
  assign start_ev  = scl_s && scl_p_q && sda_p_q && !sda_s;
  assign stop_ev   = scl_s && scl_p_q && !sda_p_q && sda_s;
  assign rise_ev   = lnk_s2_q[1] ^ tog_p_q;
  assign fall_ev   = scl_p_q && !scl_s;

  // control state
  eeprom_pkg::state_e st_q;
  eeprom_pkg::state_e nxt_q;
  logic [2:0]                        cnt_q;
  logic                              done_q;
  logic [7:0]                        sh_q;
  logic [eeprom_pkg::ADDR_W-1:0]     addr_q;
  logic                              oe_n_q;
  logic                              wr_pend_q;
  logic [eeprom_pkg::PROG_CNT_W-1:0] prog_cnt_q;
  logic [7:0]                        mem_q [eeprom_pkg::MEM_DEPTH];
  logic [7:0]                        pbuf_q [eeprom_pkg::PAGE_BYTES];
  logic [eeprom_pkg::PAGE_BYTES-1:0] pvalid_q;

  logic                          byte_end;
  logic                          dev_match;
  logic [eeprom_pkg::ADDR_W-1:0] dev_idx;
  logic                          prog_done;
  logic                          buf_wr;

  assign byte_end  = fall_ev && done_q;
  assign dev_match = (sh_q[7:4] == eeprom_pkg::DEV_CODE)
                     && (sh_q[3] == strap_h_s) && (sh_q[2] == strap_l_s);
  assign dev_idx   = {sh_q[1], addr_q[7:0]};
  assign prog_done = (st_q == eeprom_pkg::S_PROG) && (prog_cnt_q == PROG_LAST);
  assign buf_wr    = byte_end && (st_q == eeprom_pkg::S_WDATA);

  always_ff @(posedge CORE_CLK) begin
    if (!RST_N) begin
      st_q      <= eeprom_pkg::S_IDLE;
      nxt_q     <= eeprom_pkg::S_IDLE;
      cnt_q     <= 3'h0;
      done_q    <= 1'h0;
      sh_q      <= 8'h00;
      addr_q    <= 9'h000;
      oe_n_q    <= 1'h1;
      wr_pend_q <= 1'h0;
    end else if (st_q == eeprom_pkg::S_PROG) begin
      // bus ignored until the programming cycle ends
      if (prog_done) begin
        st_q <= eeprom_pkg::S_IDLE;
      end
    end else if (start_ev) begin
      st_q      <= eeprom_pkg::S_DEVADDR;
      cnt_q     <= 3'h0;
      done_q    <= 1'h0;
      oe_n_q    <= 1'h1;
      wr_pend_q <= 1'h0;
    end else if (stop_ev) begin
      oe_n_q    <= 1'h1;
      done_q    <= 1'h0;
      wr_pend_q <= 1'h0;
      if (wr_pend_q && !wp_s) begin
        st_q <= eeprom_pkg::S_PROG;
      end else begin
        st_q <= eeprom_pkg::S_IDLE;
      end
    end else begin
      unique case (st_q)
        eeprom_pkg::S_IDLE: begin
        end
        eeprom_pkg::S_DEVADDR, eeprom_pkg::S_WADDR, eeprom_pkg::S_WDATA: begin
          if (rise_ev && !done_q) begin
            sh_q   <= {sh_q[6:0], bit_s};
            cnt_q  <= cnt_q + 3'h1;
            done_q <= (cnt_q == eeprom_pkg::LAST_BIT);
          end else if (byte_end) begin
            done_q <= 1'h0;
            cnt_q  <= 3'h0;
            if (st_q == eeprom_pkg::S_DEVADDR) begin
              if (!dev_match) begin
                st_q <= eeprom_pkg::S_IDLE;
              end else begin
                oe_n_q <= 1'h0;
                st_q   <= eeprom_pkg::S_ACK;
                if (sh_q[0]) begin
                  nxt_q  <= eeprom_pkg::S_RDATA;
                  sh_q   <= mem_q[dev_idx];
                  addr_q <= dev_idx + 9'h001;
                end else begin
                  nxt_q     <= eeprom_pkg::S_WADDR;
                  addr_q[8] <= sh_q[1];
                end
              end
            end else if (st_q == eeprom_pkg::S_WADDR) begin
              addr_q[7:0] <= sh_q;
              oe_n_q      <= 1'h0;
              st_q        <= eeprom_pkg::S_ACK;
              nxt_q       <= eeprom_pkg::S_WDATA;
            end else begin
              addr_q[3:0] <= addr_q[3:0] + 4'h1;
              wr_pend_q   <= 1'h1;
              oe_n_q      <= 1'h0;
              st_q        <= eeprom_pkg::S_ACK;
              nxt_q       <= eeprom_pkg::S_WDATA;
            end
          end
        end
        eeprom_pkg::S_ACK: begin
          if (fall_ev) begin
            // end of ninth clock: release, or put out first read bit
            st_q   <= nxt_q;
            cnt_q  <= 3'h0;
            oe_n_q <= (nxt_q == eeprom_pkg::S_RDATA) ? sh_q[7] : 1'h1;
          end
        end
        eeprom_pkg::S_RDATA: begin
          if (fall_ev) begin
            if (cnt_q == eeprom_pkg::LAST_BIT) begin
              oe_n_q <= 1'h1;
              st_q   <= eeprom_pkg::S_RACK;
            end else begin
              sh_q   <= {sh_q[6:0], 1'h0};
              oe_n_q <= sh_q[6];
              cnt_q  <= cnt_q + 3'h1;
            end
          end
        end
        eeprom_pkg::S_RACK: begin
          if (rise_ev) begin
            if (!bit_s) begin
              sh_q   <= mem_q[addr_q];
              addr_q <= addr_q + 9'h001;
              st_q   <= eeprom_pkg::S_ACK;
              nxt_q  <= eeprom_pkg::S_RDATA;
            end else begin
              st_q <= eeprom_pkg::S_IDLE;
            end
          end
        end
        eeprom_pkg::S_PROG: begin
        end
      endcase
    end
  end

  // programming cycle timer
  always_ff @(posedge CORE_CLK) begin
    if (!RST_N || st_q != eeprom_pkg::S_PROG) begin
      prog_cnt_q <= '0;
    end else begin
      prog_cnt_q <= prog_cnt_q + 1'b1;
    end
  end

  // page buffer, cleared by every start outside programming
  always_ff @(posedge CORE_CLK) begin
    if (!RST_N) begin
      pvalid_q <= '0;
    end else if (start_ev && st_q != eeprom_pkg::S_PROG) begin
      pvalid_q <= '0;
    end else if (buf_wr) begin
      pvalid_q[addr_q[3:0]] <= 1'h1;
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (buf_wr) begin
      pbuf_q[addr_q[3:0]] <= sh_q;
    end
  end

  // array: buffered bytes committed when the timed cycle ends
  always_ff @(posedge CORE_CLK) begin
    for (int i = 0; i < eeprom_pkg::PAGE_BYTES; i++) begin
      if (prog_done && pvalid_q[i]) begin
        mem_q[{addr_q[8:4], i[3:0]}] <= pbuf_q[i];
      end
    end
  end

  // output flops
  logic sda_out_q;
  logic standby_q;

  always_ff @(posedge CORE_CLK) begin
    if (!RST_N) begin
      sda_out_q <= 1'h0;
      standby_q <= 1'h1;
    end else begin
      sda_out_q <= 1'h0;
      standby_q <= (st_q == eeprom_pkg::S_IDLE);
    end
  end

  assign SDA_OUT  = sda_out_q;
  assign SDA_OE_N = oe_n_q;
  assign STANDBY  = standby_q;

  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (!RST_N);

  a_start_to_addr: assert property (start_ev && st_q != eeprom_pkg::S_PROG |=> st_q == eeprom_pkg::S_DEVADDR)
    else $error("start not taken");
  a_stop_ends: assert property (stop_ev |=> st_q == eeprom_pkg::S_IDLE || st_q == eeprom_pkg::S_PROG)
    else $error("stop did not end transaction");
  a_drive_on_fall: assert property (!oe_n_q && $past(oe_n_q) |-> $past(fall_ev))
    else $error("data driven outside clock fall");
  a_ack_match: assert property (byte_end && st_q == eeprom_pkg::S_DEVADDR && dev_match
                                |=> !oe_n_q && st_q == eeprom_pkg::S_ACK)
    else $error("matching address not acknowledged");
  a_nomatch_idle: assert property (byte_end && st_q == eeprom_pkg::S_DEVADDR && !dev_match
                                   |=> oe_n_q && st_q == eeprom_pkg::S_IDLE)
    else $error("mismatch acknowledged");
  a_prog_silent: assert property (st_q == eeprom_pkg::S_PROG |-> oe_n_q)
    else $error("drive during programming");
  a_wp_blocks: assert property (stop_ev && st_q == eeprom_pkg::S_WDATA && wp_s |=> st_q == eeprom_pkg::S_IDLE)
    else $error("programming despite write protect");
  a_prog_start: assert property (stop_ev && st_q == eeprom_pkg::S_WDATA && wr_pend_q && !wp_s
                                 |=> st_q == eeprom_pkg::S_PROG && prog_cnt_q == '0)
    else $error("programming not started at stop");
  a_page_wrap: assert property (buf_wr |=> addr_q[8:4] == $past(addr_q[8:4])
                                && addr_q[3:0] == $past(addr_q[3:0]) + 4'h1)
    else $error("page address advanced wrongly");
  a_read_incr: assert property (rise_ev && st_q == eeprom_pkg::S_RACK && !bit_s
                                |=> addr_q == $past(addr_q) + 9'h001 && st_q == eeprom_pkg::S_ACK)
    else $error("sequential read did not advance");
endmodule

// file: verification/i2c_master_model.sv
// two-wire bus master model driving the serial memory slave
`timescale 1ns/1ps
module i2c_master_model #(
  parameter int HALF = 25
) (
  input  wire logic clk,  // core clock, paces the bus phases
  input  wire logic sda,  // resolved data wire level
  output logic      scl,  // serial clock to the slave
  output logic      sda_o // 1 releases the wire, 0 pulls it low
);
  initial begin
    scl   = 1'b1;
    sda_o = 1'b1;
  end

  // change after a core edge, then hold for n edges
  task automatic drive(input logic s, input logic d, input int n);
    @(posedge clk);
    scl   <= s;
    sda_o <= d;
    repeat (n) @(posedge clk);
  endtask

  // end any open clock (a pending ack holds data low), free data while low
  task automatic start();
    drive(1'b0, sda_o, 12);
    drive(1'b0, 1'b1, 12);
    drive(1'b1, 1'b1, HALF);
    drive(1'b1, 1'b0, HALF);
  endtask

  task automatic stop();
    drive(1'b0, sda_o, 12);
    drive(1'b0, 1'b0, 12);
    drive(1'b1, 1'b0, HALF);
    drive(1'b1, 1'b1, HALF);
  endtask

  // data moves only while the clock is low, sampled late in the high phase
  task automatic xfer(input logic b, output logic r);
    drive(1'b0, sda_o, 12);
    drive(1'b0, b, 12);
    drive(1'b1, b, HALF);
    r = sda;
  endtask

  task automatic tx_byte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      xfer(d[i], r);
    end
    xfer(1'b1, ack);
  endtask

  task automatic rx_byte(input logic ack_n, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      xfer(1'b1, d[i]);
    end
    xfer(ack_n, r);
  endtask

  task automatic recover();
    repeat (9) begin
      drive(1'b0, 1'b1, 12);
      drive(1'b1, 1'b1, HALF);
    end
    start();
  endtask
endmodule

// file: verification/testbench.sv
// self-checking bench for the two-wire memory slave
`timescale 1ns/1ps
module testbench;
  logic       CORE_CLK;
  logic       RST_N;
  logic       WRITE_PROTECT;
  logic [1:0] strap_q;
  logic       SDA_OUT;
  logic       SDA_OE_N;
  logic       STANDBY;
  logic       scl;
  logic       sda_o;
  wire        SDA = sda_o & (SDA_OE_N | SDA_OUT);
  logic [7:0] mem_m [512];
  int         error_cnt;
  int         num_checks;
  logic       ack;
  logic [7:0] rd;

  i2c_eeprom_slave_512b #(.PROG_CYCLES(1000)) i2c_eeprom_slave_512b_i (
    .CORE_CLK(CORE_CLK), .RST_N(RST_N), .SCL(scl), .SDA_IN(SDA), .SDA_OUT(SDA_OUT),
    .SDA_OE_N(SDA_OE_N), .WRITE_PROTECT(WRITE_PROTECT), .CHIP_SELECT_STRAP_HIGH(strap_q[1]),
    .CHIP_SELECT_STRAP_LOW(strap_q[0]), .STANDBY(STANDBY));
  i2c_master_model #(.HALF(25)) i2c_master_model_i (.clk(CORE_CLK), .sda(SDA), .scl(scl), .sda_o(sda_o));

  initial begin
    CORE_CLK = 1'b0;
    forever #2 CORE_CLK = ~CORE_CLK;
  end

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("unexpected at %0t ns: seen %0h expected %0h", $time, seen, exp);
    end
  endtask

  task automatic end_sim();
    $display("checks %0d errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  function automatic logic [7:0] dev(input logic [1:0] st, input logic b8, input logic rw);
    return {eeprom_pkg::DEV_CODE, st, b8, rw};
  endfunction

  task automatic send(input logic [7:0] d, input logic exp_ack);
    i2c_master_model_i.tx_byte(d, ack);
    check(ack, exp_ack);
  endtask

  task automatic page_write(input logic [8:0] a, input int n, input logic [7:0] base, input logic upd);
    i2c_master_model_i.start();
    send(dev(strap_q, a[8], 1'b0), 1'b0);
    send(a[7:0], 1'b0);
    for (int i = 0; i < n; i++) begin
      send(base + 8'(i), 1'b0);
      if (upd) begin
        mem_m[{a[8:4], 4'(a[3:0] + i)}] = base + 8'(i);
      end
    end
    i2c_master_model_i.stop();
  endtask

  task automatic read_check(input logic [8:0] a, input int n);
    i2c_master_model_i.start();
    send(dev(strap_q, a[8], 1'b0), 1'b0);
    send(a[7:0], 1'b0);
    i2c_master_model_i.start();
    send(dev(strap_q, a[8], 1'b1), 1'b0);
    for (int i = 0; i < n; i++) begin
      i2c_master_model_i.rx_byte(i == n - 1, rd);
      check(rd, mem_m[9'(a + i)]);
    end
    i2c_master_model_i.stop();
  endtask

  task automatic wait_prog();
    for (int i = 0; i < 3000 && STANDBY !== 1'b1; i++) begin
      @(posedge CORE_CLK);
    end
    if (STANDBY !== 1'b1) begin
      error_cnt++;
      end_sim();
    end
  endtask

  task automatic t_mismatch();
    i2c_master_model_i.start();
    send(dev(~strap_q, 1'b0, 1'b0), 1'b1);
    i2c_master_model_i.stop();
    i2c_master_model_i.start();
    send({4'hB, strap_q, 2'h0}, 1'b1);
    i2c_master_model_i.stop();
  endtask

  task automatic t_byte_write();
    page_write(9'h000, 1, 8'h5A, 1'b1);
    check(STANDBY, 1'b0);
    i2c_master_model_i.start();
    send(dev(strap_q, 1'b0, 1'b0), 1'b1);
    i2c_master_model_i.stop();
    wait_prog();
    i2c_master_model_i.start();
    send(dev(strap_q, 1'b0, 1'b0), 1'b0);
    i2c_master_model_i.stop();
  endtask

  task automatic t_page_and_wrap();
    page_write(9'h1FE, 18, 8'h10, 1'b1);
    wait_prog();
    read_check(9'h1F0, 16);
    i2c_master_model_i.start();
    send(dev(strap_q, 1'b0, 1'b1), 1'b0);
    i2c_master_model_i.rx_byte(1'b1, rd);
    check(rd, mem_m[0]);
    i2c_master_model_i.stop();
  endtask

  task automatic t_protect();
    @(posedge CORE_CLK);
    WRITE_PROTECT <= 1'b1;
    page_write(9'h000, 1, 8'hA5, 1'b0);
    check(STANDBY, 1'b1);
    @(posedge CORE_CLK);
    WRITE_PROTECT <= 1'b0;
    read_check(9'h000, 1);
  endtask

  task automatic t_recover();
    i2c_master_model_i.start();
    for (int i = 0; i < 3; i++) begin
      i2c_master_model_i.xfer(i[0], ack);
    end
    i2c_master_model_i.recover();
    send(dev(strap_q, 1'b0, 1'b0), 1'b0);
    i2c_master_model_i.stop();
  endtask

  initial begin
    RST_N         = 1'b0;
    WRITE_PROTECT = 1'b0;
    strap_q       = 2'h2;
    error_cnt     = 0;
    num_checks    = 0;
    repeat (20) @(posedge CORE_CLK);
    RST_N <= 1'b1;
    repeat (8) @(posedge CORE_CLK);
    check(STANDBY, 1'b1);
    check(SDA_OE_N, 1'b1);
    t_mismatch();
    t_byte_write();
    t_page_and_wrap();
    t_protect();
    t_recover();
    end_sim();
  end
endmodule
